// >>> logic/rts_consts.svh
// Constants for the reset and time-out sequencer: offsets, bit positions,
// reset values and timing counts. Assumes a 250 MHz hclk.
`ifndef RTS_CONSTS_SVH
`define RTS_CONSTS_SVH

`define RTS_CLK_NS        4
`define RTS_POWERUP_TIMER_CYCLES   2048
`define RTS_OST_CYCLES    1024
`define RTS_PLL_NS        2000000
`define RTS_PLL_CYCLES    ((`RTS_PLL_NS + `RTS_CLK_NS - 1) / `RTS_CLK_NS)
`define RTS_CNT_W         24
`define RTS_PC_W          21
`define RTS_PC_STEP       21'h0_0002
`define RTS_PC_ZERO       21'h0_0000

`define RTS_ADDR_STATUS   8'h00
`define RTS_ADDR_SEQ      8'h04
`define RTS_ADDR_KEEP     8'h08

`define RTS_B_BOR         0
`define RTS_B_POR         1
`define RTS_B_PD          2
`define RTS_B_TO          3
`define RTS_B_RI          4
`define RTS_B_SBE         6
`define RTS_B_OVF         8
`define RTS_B_UNF         9

`define RTS_BOR_OFF       2'h0
`define RTS_BOR_SOFT      2'h1
`define RTS_BOR_NOSLEEP   2'h2
`define RTS_BOR_ON        2'h3

`endif

// >>> logic/rts_pkg.sv
// Types for the reset and time-out sequencer.
// Assumes rts_consts.svh is on the include path.
`include "rts_consts.svh"

package rts_pkg;

  typedef enum logic [5:0] {
    ST_HOLD = 6'h01,
    ST_POWERUP_TIMER = 6'h02,
    ST_OST  = 6'h04,
    ST_PLL  = 6'h08,
    ST_WAIT = 6'h10,
    ST_RUN  = 6'h20
  } rts_state_e;

  typedef enum logic [2:0] {
    OSC_LOW_POWER_CRYSTAL = 3'h0,
    OSC_MID_CRYSTAL       = 3'h1,
    OSC_FAST_CRYSTAL      = 3'h2,
    OSC_FAST_CRYSTAL_X4   = 3'h3,
    OSC_EXTERNAL_CLOCK_IN = 3'h4,
    OSC_RESISTOR_CAP      = 3'h5,
    OSC_INTERNAL          = 3'h6
  } rts_osc_e;

  typedef enum logic [1:0] {
    PM_FULL  = 2'h0,
    PM_RUN   = 2'h1,
    PM_IDLE  = 2'h2,
    PM_SLEEP = 2'h3
  } rts_pm_e;

  typedef struct packed {
    logic [1:0] brownout_mode_select;
    logic       powerup_timer_disable;
    rts_osc_e   osc_mode;
    logic       stack_error_reset_enable;
  } rts_cfg_s;

  typedef struct packed {
    logic reset_instr;
    logic wdt_timeout;
    logic stack_full;
    logic stack_underflow;
    logic wake_irq;
  } rts_evt_s;

  typedef struct packed {
    logic sbe;
    logic ri;
    logic to;
    logic pd;
    logic por;
    logic bor;
    logic ovf;
    logic unf;
  } rts_flags_s;

  typedef struct packed {
    rts_state_e             st;
    logic [`RTS_CNT_W-1:0]  cnt;
    rts_flags_s             fl;
    logic [`RTS_PC_W-1:0]   pc;
    logic                   pc_load;
    logic                   hold;
    logic                   wake;
    logic                   bor_on;
    logic                   ph_act;
    logic                   ph_wr;
    logic [7:0]             ph_addr;
    logic [31:0]            rdata;
  } rts_regs_s;

endpackage : rts_pkg

// >>> logic/rts_sequencer.sv
// Reset and time-out sequencer with an AHB-Lite register slave.
// Assumes detector, oscillator tick and core event inputs are synchronous
// to hclk, and that hresetn is asserted once at power-up.
//
// How it works
// - Mode 10: protection on except in Sleep
// - Mode 00: protection off, soft enable unavailable
// - Mode 01: soft enable alone decides protection
// - Mode 11: protection always on
// - Power-up timer counts 2048 slow oscillator ticks
// - Power-up delay only when disable bit zero
// - Oscillator timer counts 1024 ticks after power-up
// - Oscillator delay crystal modes, power-on or wake
// - PLL mode adds lock delay after oscillator
// - Power-on pulse ends, then delays in order
// - Non-crystal modes: power-up delay only
// - Delays ignore clear pin; release on pin high
// - Unaffected word survives resets; others reload
// - Watchdog wake keeps registers, resumes execution
// - Power-on and brown-out flag and PC values
// - Watchdog in run: reset, clear timeout flag
// - Watchdog in Idle/Sleep: resume PC+2, clear two
// - Clear pin reset flags depend on mode
// - Underflow always sets its flag; overflow flags and resets only if enabled
// - Interrupt wake: resume PC+2, clear powerdown flag
// - Soft enable reset value by reset type
// - Brown-out restarts power-up delay from zero
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps

module rts_sequencer
  import rts_pkg::*;
#(
  parameter int POWERUP_TIMER_CYC     = `RTS_POWERUP_TIMER_CYCLES,
  parameter int OST_CYC      = `RTS_OST_CYCLES,
  parameter int PLL_LOCK_CYC = `RTS_PLL_CYCLES
)(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic                 por_pulse,
  input  wire logic                 brownout_detect,
  input  wire logic                 master_clear_pin_n,
  input  wire logic                 low_freq_osc_tick,
  input  wire logic                 osc_tick,
  input  wire logic                 osc_stopped,
  input  wire rts_pm_e              pm_mode,
  input  wire rts_cfg_s             cfg,
  input  wire rts_evt_s             evt,
  input  wire logic [`RTS_PC_W-1:0] cur_pc,
  output logic                      core_hold,
  output logic                      pc_load,
  output logic [`RTS_PC_W-1:0]      pc_value,
  output logic                      brownout_enabled,
  output rts_flags_s                status_flags
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic is_crystal(input rts_osc_e m);
    is_crystal = (m == OSC_LOW_POWER_CRYSTAL) || (m == OSC_MID_CRYSTAL) ||
                 (m == OSC_FAST_CRYSTAL) || (m == OSC_FAST_CRYSTAL_X4);
  endfunction : is_crystal

  function automatic logic soft_mode(input logic [1:0] sel);
    soft_mode = (sel == `RTS_BOR_SOFT);
  endfunction : soft_mode

  localparam logic [10:0]            POWERUP_TIMER_LAST = 11'(POWERUP_TIMER_CYC - 1);
  localparam logic [`RTS_CNT_W-1:0]  OST_LAST  = `RTS_CNT_W'(OST_CYC - 1);
  localparam logic [`RTS_CNT_W-1:0]  PLL_LAST  = `RTS_CNT_W'(PLL_LOCK_CYC - 1);
  localparam logic [`RTS_CNT_W-1:0]  CNT_ZERO  = `RTS_CNT_W'(0);
  localparam logic [`RTS_CNT_W-1:0]  CNT_ONE   = `RTS_CNT_W'(1);

  rts_regs_s   r;
  rts_regs_s   n;
  logic [31:0] keep_r;
  logic        wr_status;
  logic        bor_trip;
  logic        sleeping;
  logic        do_reset;
  logic        do_wake;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    n          = r;
    n.pc_load  = 1'b0;
    do_reset   = 1'b0;
    do_wake    = 1'b0;
    sleeping   = (pm_mode == PM_IDLE) || (pm_mode == PM_SLEEP);
    wr_status  = r.ph_act && r.ph_wr && (r.ph_addr == `RTS_ADDR_STATUS);

    // Software writes first, so hardware events below win a tie
    if (wr_status)
    begin
      n.fl.sbe = hwdata[`RTS_B_SBE] & soft_mode(cfg.brownout_mode_select);
      n.fl.ri  = hwdata[`RTS_B_RI];
      n.fl.por = hwdata[`RTS_B_POR];
      n.fl.bor = hwdata[`RTS_B_BOR];
      n.fl.ovf = hwdata[`RTS_B_OVF];
      n.fl.unf = hwdata[`RTS_B_UNF];
    end

    // Brown-out protection enable, by configuration mode
    case (cfg.brownout_mode_select)
      `RTS_BOR_OFF:     n.bor_on = 1'b0;
      `RTS_BOR_SOFT:    n.bor_on = r.fl.sbe;
      `RTS_BOR_NOSLEEP: n.bor_on = (pm_mode != PM_SLEEP);
      `RTS_BOR_ON:      n.bor_on = 1'b1;
      default:          n.bor_on = 1'b0;
    endcase
    bor_trip = r.bor_on && brownout_detect;

    // Sequencer
    case (r.st)
      ST_HOLD:
      begin
        n.cnt = CNT_ZERO;
        if (!por_pulse && !bor_trip)
        begin
          if (!cfg.powerup_timer_disable)
            n.st = ST_POWERUP_TIMER;
          else if (is_crystal(cfg.osc_mode))
            n.st = ST_OST;
          else
            n.st = ST_WAIT;
        end
      end
      ST_POWERUP_TIMER:
      begin
        if (low_freq_osc_tick)
        begin
          n.cnt = r.cnt + CNT_ONE;
          if (r.cnt[10:0] == POWERUP_TIMER_LAST)
          begin
            n.cnt = CNT_ZERO;
            n.st  = is_crystal(cfg.osc_mode) ? ST_OST : ST_WAIT;
          end
        end
      end
      ST_OST:
      begin
        if (osc_tick)
        begin
          n.cnt = r.cnt + CNT_ONE;
          if (r.cnt == OST_LAST)
          begin
            n.cnt = CNT_ZERO;
            n.st  = (cfg.osc_mode == OSC_FAST_CRYSTAL_X4) ? ST_PLL : ST_WAIT;
          end
        end
      end
      ST_PLL:
      begin
        n.cnt = r.cnt + CNT_ONE;
        if (r.cnt == PLL_LAST)
        begin
          n.cnt = CNT_ZERO;
          n.st  = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // Pin only gates release, never the delays themselves
        if (r.wake || master_clear_pin_n)
        begin
          n.st      = ST_RUN;
          n.pc_load = 1'b1;
          n.wake    = 1'b0;
        end
      end
      ST_RUN:
      begin
        // Priority: pin, stack, reset instruction, watchdog, interrupt
        if (!master_clear_pin_n)
        begin
          do_reset = 1'b1;
          if (sleeping)
          begin
            n.fl.to = 1'b1;
            n.fl.pd = 1'b0;
          end
          else if (pm_mode == PM_RUN)
            n.fl.to = 1'b1;
        end
        else if (evt.stack_full && cfg.stack_error_reset_enable)
        begin
          n.fl.ovf = 1'b1;
          do_reset = 1'b1;
        end
        else if (evt.stack_underflow)
        begin
          n.fl.unf = 1'b1;
          do_reset = cfg.stack_error_reset_enable;
        end
        else if (evt.reset_instr)
        begin
          n.fl.ri  = 1'b0;
          do_reset = 1'b1;
        end
        else if (evt.wdt_timeout)
        begin
          n.fl.to = 1'b0;
          if (sleeping)
          begin
            n.fl.pd = 1'b0;
            do_wake = 1'b1;
          end
          else
            do_reset = 1'b1;
        end
        else if (evt.wake_irq && sleeping)
        begin
          n.fl.pd = 1'b0;
          do_wake = 1'b1;
        end
        if (do_reset)
        begin
          n.st     = ST_WAIT;
          n.wake   = 1'b0;
          n.pc     = `RTS_PC_ZERO;
          n.fl.sbe = r.fl.sbe & soft_mode(cfg.brownout_mode_select);
        end
        else if (do_wake)
        begin
          n.pc   = cur_pc + `RTS_PC_STEP;
          n.wake = 1'b1;
          // A stopped crystal must restart before the core runs
          if (osc_stopped && is_crystal(cfg.osc_mode))
          begin
            n.st  = ST_OST;
            n.cnt = CNT_ZERO;
          end
          else
            n.pc_load = 1'b1;
        end
      end
      default:
        n.st = ST_HOLD;
    endcase

    // Brown-out overrides the sequence and restarts every delay
    if (bor_trip)
    begin
      n.st     = ST_HOLD;
      n.cnt    = CNT_ZERO;
      n.wake   = 1'b0;
      n.pc     = `RTS_PC_ZERO;
      n.fl.ri  = 1'b1;
      n.fl.to  = 1'b1;
      n.fl.pd  = 1'b1;
      n.fl.bor = 1'b0;
      n.fl.sbe = r.fl.sbe & soft_mode(cfg.brownout_mode_select);
      n.pc_load = 1'b0;
    end
    if (por_pulse)
    begin
      n.st      = ST_HOLD;
      n.cnt     = CNT_ZERO;
      n.wake    = 1'b0;
      n.pc      = `RTS_PC_ZERO;
      n.fl      = '{sbe: 1'b1, ri: 1'b1, to: 1'b1, pd: 1'b1,
                    por: 1'b0, bor: 1'b0, ovf: 1'b0, unf: 1'b0};
      n.pc_load = 1'b0;
    end

    n.hold = (n.st != ST_RUN);

    // Bus address phase; reads answer from a flop in the data phase
    n.ph_act  = hsel && htrans[1] && hready;
    n.ph_wr   = hwrite;
    n.ph_addr = haddr[7:0];
    n.rdata   = 32'h0000_0000;
    if (n.ph_act && !hwrite)
    begin
      case (haddr[7:0])
        `RTS_ADDR_STATUS:
          n.rdata = {22'h00_0000, r.fl.unf, r.fl.ovf, 1'b0,
                     r.fl.sbe & soft_mode(cfg.brownout_mode_select), 1'b0,
                     r.fl.ri, r.fl.to, r.fl.pd, r.fl.por, r.fl.bor};
        `RTS_ADDR_SEQ:
          n.rdata = {23'h00_0000, r.bor_on, r.hold, r.wake, r.st};
        `RTS_ADDR_KEEP:
          n.rdata = keep_r;
        default:
          n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r         <= '0;
      r.st      <= ST_HOLD;
      r.hold    <= 1'b1;
      r.fl.sbe  <= 1'b1;
      r.fl.ri   <= 1'b1;
      r.fl.to   <= 1'b1;
      r.fl.pd   <= 1'b1;
    end
    else
      r <= n;
  end

  // Unaffected word: no reset, so unknown until first written
  always_ff @(posedge hclk)
  begin
    if (r.ph_act && r.ph_wr && (r.ph_addr == `RTS_ADDR_KEEP))
      keep_r <= hwdata;
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign hrdata           = r.rdata;
  assign core_hold        = r.hold;
  assign pc_load          = r.pc_load;
  assign pc_value         = r.pc;
  assign brownout_enabled = r.bor_on;
  assign status_flags     = r.fl;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_BOR_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg.brownout_mode_select == `RTS_BOR_OFF |=> !brownout_enabled)
    else $error("protection on in mode 00");

  AST_BOR_SLEEP: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg.brownout_mode_select == `RTS_BOR_NOSLEEP |=>
      brownout_enabled == ($past(pm_mode) != PM_SLEEP))
    else $error("mode 10 sleep gating wrong");

  AST_BOR_ON: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg.brownout_mode_select == `RTS_BOR_ON |=> brownout_enabled)
    else $error("protection off in mode 11");

  AST_POR_FLAGS: assert property (@(posedge hclk) disable iff (!hresetn)
    por_pulse |=> core_hold && !status_flags.por && status_flags.ri &&
      status_flags.to && status_flags.pd && pc_value == `RTS_PC_ZERO)
    else $error("power-on flags wrong");

  AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == ST_POWERUP_TIMER) |-> core_hold [*2])
    else $error("core released during delay");

  AST_POWERUP_TIMER_END: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == ST_POWERUP_TIMER && low_freq_osc_tick && r.cnt[10:0] == POWERUP_TIMER_LAST &&
     !por_pulse && !bor_trip) |=> (r.st != ST_POWERUP_TIMER) && (r.cnt == CNT_ZERO))
    else $error("power-up timer end wrong");

  AST_WDT_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == ST_RUN && master_clear_pin_n && !evt.stack_full &&
     !evt.stack_underflow && !evt.reset_instr && evt.wdt_timeout &&
     (pm_mode == PM_FULL || pm_mode == PM_RUN) && !por_pulse && !bor_trip)
      |=> !status_flags.to && core_hold && pc_value == `RTS_PC_ZERO)
    else $error("watchdog reset wrong");

  AST_WDT_WAKE: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == ST_RUN && master_clear_pin_n && !evt.stack_full &&
     !evt.stack_underflow && !evt.reset_instr && evt.wdt_timeout &&
     sleeping && !(osc_stopped && is_crystal(cfg.osc_mode)) && !por_pulse && !bor_trip)
      |=> !status_flags.to && !status_flags.pd && pc_load && !core_hold &&
          pc_value == $past(cur_pc) + `RTS_PC_STEP)
    else $error("watchdog wake wrong");

  AST_RI: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == ST_RUN && master_clear_pin_n && !evt.stack_full &&
     !evt.stack_underflow && evt.reset_instr && !por_pulse && !bor_trip)
      |=> !status_flags.ri && core_hold)
    else $error("reset instruction flag wrong");

  AST_BOR_TRIP: assert property (@(posedge hclk) disable iff (!hresetn)
    (bor_trip && !por_pulse) |=> r.st == ST_HOLD && !status_flags.bor &&
      r.cnt == CNT_ZERO)
    else $error("brown-out did not restart delays");

endmodule : rts_sequencer

// >>> sim/rts_osc_model.sv
// Oscillator and clock-stop model facing the reset and time-out sequencer.
// Assumes one hclk domain; the main oscillator halts in Sleep until woken.
`timescale 1ns/100ps

module rts_osc_model
  import rts_pkg::*;
#(
  parameter int LF_DIV = 4,
  parameter int OS_DIV = 2
)(
  input  wire logic    hclk,
  input  wire logic    hresetn,
  input  wire rts_pm_e pm_mode,
  input  wire logic    core_hold,
  input  wire logic    pc_load,
  output logic         low_freq_osc_tick,
  output logic         osc_tick,
  output logic         osc_stopped
);
  // ------------------------------------------------------------
  // Tick generators
  // ------------------------------------------------------------
  int   lf_cnt;
  int   os_cnt;
  logic halt;

  // Main oscillator stands still while the core sleeps
  assign halt = (pm_mode == PM_SLEEP) && !core_hold;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lf_cnt            <= 0;
      os_cnt            <= 0;
      low_freq_osc_tick <= 1'b0;
      osc_tick          <= 1'b0;
      osc_stopped       <= 1'b0;
    end
    else
    begin
      lf_cnt            <= (lf_cnt == LF_DIV - 1) ? 0 : lf_cnt + 1;
      low_freq_osc_tick <= (lf_cnt == LF_DIV - 1);
      os_cnt            <= (halt || os_cnt == OS_DIV - 1) ? 0 : os_cnt + 1;
      osc_tick          <= !halt && (os_cnt == OS_DIV - 1);
      // Stop flag lives until the core is released again
      if (pm_mode == PM_SLEEP)
        osc_stopped <= 1'b1;
      else if (pc_load)
        osc_stopped <= 1'b0;
    end
  end
endmodule : rts_osc_model

// >>> sim/reset_timeout_sequencer_test.sv
// Self-checking bench for the reset and time-out sequencer.
// Assumes rts_consts.svh on the include path and a zero-wait bus slave.
`timescale 1ns/100ps
`include "rts_consts.svh"

module reset_timeout_sequencer_test
  import rts_pkg::*;
;
  localparam int PW = 8;
  localparam int OS = 4;
  localparam int PL = 20;
  localparam int LF = 4;
  localparam int OD = 2;

  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, por_pulse = 1'b1, brownout_detect = 1'b0;
  logic        master_clear_pin_n = 1'b0, lf_tick, os_tick, os_stop;
  logic        core_hold, pc_load, brownout_enabled;
  logic [20:0] cur_pc = 21'h0, pc_value;
  rts_pm_e     pm_mode = PM_FULL;
  rts_cfg_s    cfg = '{2'h1, 1'b0, OSC_FAST_CRYSTAL_X4, 1'b1};
  rts_evt_s    evt = '0;
  rts_flags_s  status_flags, exp_fl;
  int          fail_count = 0, check_count = 0, cyc = 0;
  int          ks[10] = '{0, 1, 5, 4, 5, 2, 3, 3, 1, 5};
  rts_pm_e     ps[10] = '{PM_FULL, PM_RUN, PM_RUN, PM_IDLE, PM_FULL,
                          PM_FULL, PM_FULL, PM_FULL, PM_SLEEP, PM_IDLE};

  rts_sequencer #(.POWERUP_TIMER_CYC(PW), .OST_CYC(OS), .PLL_LOCK_CYC(PL)) u_rts_sequencer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .por_pulse(por_pulse),
    .brownout_detect(brownout_detect), .master_clear_pin_n(master_clear_pin_n),
    .low_freq_osc_tick(lf_tick), .osc_tick(os_tick), .osc_stopped(os_stop),
    .pm_mode(pm_mode), .cfg(cfg), .evt(evt), .cur_pc(cur_pc), .core_hold(core_hold),
    .pc_load(pc_load), .pc_value(pc_value), .brownout_enabled(brownout_enabled),
    .status_flags(status_flags));

  rts_osc_model #(.LF_DIV(LF), .OS_DIV(OD)) u_rts_osc_model (
    .hclk(hclk), .hresetn(hresetn), .pm_mode(pm_mode), .core_hold(core_hold),
    .pc_load(pc_load), .low_freq_osc_tick(lf_tick), .osc_tick(os_tick),
    .osc_stopped(os_stop));

  always #2 hclk = ~hclk;

  // ------------------------------------------------------------
  // Checks and expectations
  // ------------------------------------------------------------
  task automatic end_sim;
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_v

  task automatic chk_fl(input rts_flags_s got, input rts_flags_s exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t flags %b expected %b", $time, got, exp);
    end
  endtask : chk_fl

  function automatic logic [31:0] exp_stat(rts_flags_s f, logic [1:0] m);
    exp_stat = {22'h0, f.unf, f.ovf, 1'b0, f.sbe & (m == 2'h1), 1'b0,
                f.ri, f.to, f.pd, f.por, f.bor};
  endfunction : exp_stat

  function automatic rts_flags_s nxt_fl(rts_flags_s f, int k, rts_pm_e p);
    nxt_fl = f;
    if (k == 0) nxt_fl.ri = 1'b0;
    if (k == 1) nxt_fl.to = 1'b0;
    if (k == 5 && p != PM_FULL) nxt_fl.to = 1'b1;
    if (((k == 1 || k == 5) && p >= PM_IDLE) || k == 4) nxt_fl.pd = 1'b0;
    if (k == 2) nxt_fl.ovf = 1'b1;
    if (k == 3) nxt_fl.unf = 1'b1;
    if (k == 6) {nxt_fl.ri, nxt_fl.to, nxt_fl.pd, nxt_fl.bor} = 4'he;
  endfunction : nxt_fl

  // ------------------------------------------------------------
  // Bus and event drivers
  // ------------------------------------------------------------
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk_v({31'h0, hresp}, 32'h0);
  endtask : ahb

  // Bounded wait for the core release pulse
  task automatic wait_load(output int n);
    n = 0;
    while (pc_load !== 1'b1 && n < 200)
    begin
      @(posedge hclk);
      n++;
    end
  endtask : wait_load

  task automatic do_evt(input int k, input rts_pm_e p, input int lo);
    rts_evt_s    e;
    logic [20:0] pc;
    int          n;
    e = '0;
    e.reset_instr = (k == 0);
    e.wdt_timeout = (k == 1);
    e.stack_full = (k == 2);
    e.stack_underflow = (k == 3);
    e.wake_irq = (k == 4);
    pc = 21'($urandom) & 21'h1f_fffe;
    @(posedge hclk);
    pm_mode <= p;
    cur_pc  <= pc;
    @(posedge hclk);
    evt                <= e;
    master_clear_pin_n <= (k != 5);
    @(posedge hclk);
    evt <= '0;
    if (k == 5) repeat (2) @(posedge hclk);
    master_clear_pin_n <= 1'b1;
    exp_fl = nxt_fl(exp_fl, k, p);
    if (k != 3 || cfg.stack_error_reset_enable)
    begin
      wait_load(n);
      chk_v(32'(n >= lo && n < 200), 32'h1);
      chk_v(32'(pc_value), (k == 4 || (k == 1 && p >= PM_IDLE)) ? 32'(pc + 21'h2) : 32'h0);
    end
    else
    begin
      repeat (3) @(posedge hclk);
      chk_v({31'h0, core_hold}, 32'h0);
    end
    chk_fl(status_flags, exp_fl);
    pm_mode <= PM_FULL;
  endtask : do_evt

  // Hang guard: a stalled sequence ends the run as a failure
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fail_count++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    int          n;
    logic [31:0] rd;
    logic [31:0] kw;
    void'($urandom(99409));
    exp_fl = rts_flags_s'(8'hf0);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    por_pulse <= 1'b0;
    n = 0;
    rd = 32'h0;
    // Pin held low: the delays still run to the end
    while (rd[5:0] !== 6'h10 && n < 400)
    begin
      ahb(1'b0, `RTS_ADDR_SEQ, 32'h0, rd);
      n += 3;
    end
    chk_v(rd & 32'h0000_00ff, 32'h0000_0090);
    chk_v(32'(n >= PW*LF + OS*OD + PL - 5 && n <= PW*LF + OS*OD + PL + 8), 32'h1);
    chk_fl(status_flags, exp_fl);
    ahb(1'b0, `RTS_ADDR_STATUS, 32'h0, rd);
    chk_v(rd, exp_stat(exp_fl, 2'h1));
    master_clear_pin_n <= 1'b1;
    wait_load(n);
    chk_v(32'(n <= 3), 32'h1);
    chk_v(32'(pc_value), 32'h0);
    cfg.osc_mode <= OSC_EXTERNAL_CLOCK_IN;
    cfg.powerup_timer_disable <= 1'b1;
    por_pulse <= 1'b1;
    repeat (3) @(posedge hclk);
    por_pulse <= 1'b0;
    wait_load(n);
    chk_v(32'(n <= 4), 32'h1);
    cfg.powerup_timer_disable <= 1'b0;
    kw = $urandom;
    ahb(1'b1, `RTS_ADDR_KEEP, kw, rd);
    ahb(1'b1, 8'h0c, ~kw, rd);
    ahb(1'b0, 8'h0c, 32'h0, rd);
    chk_v(rd, 32'h0);
    exp_fl.por = 1'b1;
    exp_fl.bor = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      for (int s = 0; s < 2; s++)
      begin
        exp_fl.sbe = (s == 0);
        cfg.brownout_mode_select <= m[1:0];
        pm_mode <= s ? PM_SLEEP : PM_FULL;
        ahb(1'b1, `RTS_ADDR_STATUS, exp_stat(exp_fl, 2'h1), rd);
        repeat (2) @(posedge hclk);
        chk_v({31'h0, brownout_enabled}, 32'(m == 3 || (m != 0 && s == 0)));
        ahb(1'b0, `RTS_ADDR_STATUS, 32'h0, rd);
        chk_v(rd, exp_stat(exp_fl, m[1:0]));
      end
    end
    pm_mode <= PM_FULL;
    for (int i = 0; i < 10; i++)
    begin
      cfg.stack_error_reset_enable <= (i != 7);
      do_evt(ks[i], ps[i], 1);
    end
    @(posedge hclk);
    brownout_detect <= 1'b1;
    repeat (4) @(posedge hclk);
    chk_v({31'h0, core_hold}, 32'h1);
    brownout_detect <= 1'b0;
    repeat (10) @(posedge hclk);
    brownout_detect <= 1'b1;
    repeat (3) @(posedge hclk);
    brownout_detect <= 1'b0;
    exp_fl = nxt_fl(exp_fl, 6, PM_FULL);
    wait_load(n);
    chk_v(32'(n >= (PW - 1)*LF && n <= PW*LF + 8), 32'h1);
    chk_fl(status_flags, exp_fl);
    cfg.osc_mode <= OSC_FAST_CRYSTAL_X4;
    do_evt(1, PM_SLEEP, OS*OD + PL - 2);
    ahb(1'b0, `RTS_ADDR_KEEP, 32'h0, rd);
    chk_v(rd, kw);
    end_sim();
  end
endmodule : reset_timeout_sequencer_test
